// [rtl/vout_monitor_power_good_output_ovp.sv]
`timescale 1ns/1ps
`include "vout_mon_params.svh"

// Function
// - reported voltage comes from sense samples, 1/256 V per code
// - digital compare for ov warn, uv fault and uv warn limits
// - power good high inside the threshold window, low otherwise
// - rising threshold from pg on limit, falling from pg off limit
// - pg thresholds beyond 630 mV of vout track at 630 mV offset
// - zero delay setting asserts power good at once
// - command mode delay 0 to 10 ms in 1 ms steps
// - vid mode ignores programmed pg thresholds
// - vid mode asserts power good inside tolerance band of boot voltage
// - vid mode keeps power good through transitions until fault shutdown
// - vid mode optionally drops power good on a 0 V command
// - ov limit beyond 655 mV above vout tracks at 655 mV offset
// - ov trip signal raised 200 ns after sense exceeds limit
// - default ov response latches high side off and drops power good
// - default ov response keeps low side on until sense below limit
// - high side stays off until supply, enable or operation cycles
// - ignore response leaves conversion running on overvoltage
// - ignored overvoltage still sets status and alert
// - ov detection active in command and vid modes
module vout_monitor_power_good_output_ovp #(
    parameter int MS_CYC = `MS_CYC_DEFAULT
) (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // axi4-lite write address
    input  wire logic [11:0]           s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0]           s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // sense and regulation inputs
    input  wire vout_mon_pkg::code_t   sense_code,
    input  wire vout_mon_pkg::code_t   vout_target,
    input  wire vout_mon_pkg::code_t   boot_code,
    input  wire logic                  enable_in,
    input  wire logic                  conv_fault,
    // outputs
    output logic                       power_good_output,
    output logic                       high_side_drive,
    output logic                       low_side_drive,
    output logic                       alert_output
);
    import vout_mon_pkg::*;

    // register state
    logic [3:0]  ctrl_reg, ctrl_next;
    code_t       pg_on_reg, pg_on_next, pg_off_reg, pg_off_next;
    code_t       ovf_reg, ovf_next, ovw_reg, ovw_next;
    code_t       uvf_reg, uvf_next, uvw_reg, uvw_next;
    code_t       band_reg, band_next, vout_reg, vout_next;
    logic [3:0]  dly_reg, dly_next;
    logic [`ST_W-1:0] status_reg, status_next;
    // bus state
    logic        aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [11:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic        awready_reg, awready_next, wready_reg, wready_next, arready_reg, arready_next;
    // monitor state
    pg_state_t   pg_state_reg, pg_state_next;
    logic [16:0] ms_cnt_reg, ms_cnt_next;
    logic [3:0]  ms_left_reg, ms_left_next;
    logic [7:0]  ov_cnt_reg, ov_cnt_next;
    logic        ov_trip_reg, ov_trip_next, hs_latch_reg, hs_latch_next;
    logic        pg_reg, pg_next, hs_reg, hs_next, ls_reg, ls_next;
    logic        alert_reg, alert_next, en_d_reg, run_d_reg;
    // helper terms
    code_t       pg_on_eff, pg_off_eff, ov_eff, pg_on_lim, pg_off_lim, ov_lim;
    logic        do_write, in_window, above_off, in_band, ov_above, restart;
    logic [`ST_W-1:0] events;

    // effective limits clamp to the tracking offsets
    always_comb begin
        pg_on_lim  = vout_target - `PG_TRACK_CODE;
        pg_off_lim = vout_target - `PG_TRACK_CODE;
        ov_lim     = vout_target + `OV_TRACK_CODE;
        pg_on_eff  = (pg_on_reg < pg_on_lim) ? pg_on_lim : pg_on_reg;
        pg_off_eff = (pg_off_reg < pg_off_lim) ? pg_off_lim : pg_off_reg;
        ov_eff     = (ovf_reg > ov_lim) ? ov_lim : ovf_reg;
    end

    // window compares, rising vs falling threshold
    always_comb begin
        above_off = sense_code >= pg_off_eff;
        in_window = (pg_state_reg == PG_LOW) ?
                    (sense_code >= pg_on_eff && sense_code < ov_eff) :
                    (above_off && sense_code < ov_eff);
        in_band   = (sense_code + band_reg >= boot_code) &&
                    (sense_code <= boot_code + band_reg);
        ov_above  = sense_code > ov_eff;
        restart   = (!enable_in && en_d_reg) || (ctrl_reg[`CTRL_RUN_BIT] && !run_d_reg);
    end

    // digital warnings and faults
    always_comb begin
        events = '0;
        events[`ST_OV_FAULT] = ov_trip_reg;
        events[`ST_OV_WARN]  = sense_code > ovw_reg;
        events[`ST_UV_FAULT] = sense_code < uvf_reg;
        events[`ST_UV_WARN]  = sense_code < uvw_reg;
    end

    // axi write/read channel handling and register updates
    always_comb begin
        aw_hold_next = aw_hold_reg;
        w_hold_next  = w_hold_reg;
        awaddr_next  = awaddr_reg;
        wdata_next   = wdata_reg;
        bvalid_next  = bvalid_reg && !s_axi_bready;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg && !s_axi_rready;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        ctrl_next = ctrl_reg;
        pg_on_next = pg_on_reg;
        pg_off_next = pg_off_reg;
        ovf_next = ovf_reg;
        ovw_next = ovw_reg;
        uvf_next = uvf_reg;
        uvw_next = uvw_reg;
        band_next = band_reg;
        dly_next = dly_reg;
        status_next = status_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_next = 1'b1;
            awaddr_next  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_next = 1'b1;
            wdata_next  = s_axi_wdata;
        end
        do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = `AXI_OKAY;
            case (awaddr_reg)
                `OFF_CTRL:     ctrl_next   = wdata_reg[3:0];
                `OFF_PG_ON:    pg_on_next  = wdata_reg[15:0];
                `OFF_PG_OFF:   pg_off_next = wdata_reg[15:0];
                `OFF_OV_FAULT: ovf_next    = wdata_reg[15:0];
                `OFF_OV_WARN:  ovw_next    = wdata_reg[15:0];
                `OFF_UV_FAULT: uvf_next    = wdata_reg[15:0];
                `OFF_UV_WARN:  uvw_next    = wdata_reg[15:0];
                `OFF_VID_BAND: band_next   = wdata_reg[15:0];
                `OFF_PG_DELAY: dly_next = (wdata_reg[3:0] > `PG_DELAY_MAX) ?
                                          `PG_DELAY_MAX : wdata_reg[3:0];
                `OFF_STATUS:   status_next = status_reg & ~wdata_reg[`ST_W-1:0];
                `OFF_READ_VOUT: bresp_next = `AXI_SLVERR;
                default:       bresp_next  = `AXI_SLVERR;
            endcase
        end
        // hardware set wins over software clear
        status_next = status_next | events;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next  = `AXI_OKAY;
            rdata_next  = 32'h0000_0000;
            case (s_axi_araddr)
                `OFF_CTRL:      rdata_next = {28'h0, ctrl_reg};
                `OFF_PG_ON:     rdata_next = {16'h0, pg_on_reg};
                `OFF_PG_OFF:    rdata_next = {16'h0, pg_off_reg};
                `OFF_OV_FAULT:  rdata_next = {16'h0, ovf_reg};
                `OFF_OV_WARN:   rdata_next = {16'h0, ovw_reg};
                `OFF_UV_FAULT:  rdata_next = {16'h0, uvf_reg};
                `OFF_UV_WARN:   rdata_next = {16'h0, uvw_reg};
                `OFF_VID_BAND:  rdata_next = {16'h0, band_reg};
                `OFF_PG_DELAY:  rdata_next = {28'h0, dly_reg};
                `OFF_READ_VOUT: rdata_next = {16'h0, vout_reg};
                `OFF_STATUS:    rdata_next = {28'h0, status_reg};
                default:        rresp_next = `AXI_SLVERR;
            endcase
        end
        // write ready flags follow the hold state and read ready follows read valid, so the pins come from flops
        awready_next = !aw_hold_next;
        wready_next  = !w_hold_next;
        arready_next = !rvalid_next;
    end

    // ov trip filter, latch and drive control
    always_comb begin
        ov_cnt_next   = ov_above ? ((ov_cnt_reg == `OV_TRIP_CYC) ? ov_cnt_reg
                                                                 : ov_cnt_reg + 8'd1) : 8'd0;
        ov_trip_next  = ov_above && (ov_cnt_reg >= `OV_TRIP_CYC - 8'd1);
        hs_latch_next = hs_latch_reg;
        if (restart)
            hs_latch_next = 1'b0;
        if (ov_trip_reg && !ctrl_reg[`CTRL_OV_IGN_BIT])
            hs_latch_next = 1'b1;
        vout_next = sense_code;
        hs_next   = enable_in && ctrl_reg[`CTRL_RUN_BIT] && !hs_latch_next &&
                    !conv_fault;
        ls_next   = hs_latch_next && ov_above;
        alert_next = |status_next;
    end

    // power good state machine with assertion delay
    always_comb begin
        pg_state_next = pg_state_reg;
        ms_cnt_next   = ms_cnt_reg;
        ms_left_next  = ms_left_reg;
        if (ctrl_reg[`CTRL_VID_BIT]) begin
            // thresholds ignored in vid mode
            case (pg_state_reg)
                PG_HIGH: if (conv_fault || hs_latch_next ||
                             (ctrl_reg[`CTRL_ZERO_BIT] && vout_target == 16'h0000))
                             pg_state_next = PG_LOW;
                default: pg_state_next = (in_band && !hs_latch_next && !conv_fault) ?
                                         PG_HIGH : PG_LOW;
            endcase
        end else begin
            case (pg_state_reg)
                PG_LOW: begin
                    if (in_window && !hs_latch_next) begin
                        if (dly_reg == 4'h0) begin
                            pg_state_next = PG_HIGH;
                        end else begin
                            pg_state_next = PG_WAIT;
                            ms_cnt_next   = 17'd0;
                            ms_left_next  = dly_reg;
                        end
                    end
                end
                PG_WAIT: begin
                    if (!in_window) begin
                        pg_state_next = PG_LOW;
                    end else if (ms_cnt_reg == 17'(MS_CYC - 1)) begin
                        ms_cnt_next  = 17'd0;
                        ms_left_next = ms_left_reg - 4'd1;
                        if (ms_left_reg == 4'd1)
                            pg_state_next = PG_HIGH;
                    end else begin
                        ms_cnt_next = ms_cnt_reg + 17'd1;
                    end
                end
                PG_HIGH: if (!in_window || hs_latch_next) pg_state_next = PG_LOW;
                default: pg_state_next = PG_LOW;
            endcase
        end
        if (ov_trip_reg && !ctrl_reg[`CTRL_OV_IGN_BIT])
            pg_state_next = PG_LOW;
        pg_next = (pg_state_next == PG_HIGH);
    end

    // all registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `CTRL_RST;
            pg_on_reg <= `PG_ON_RST;
            pg_off_reg <= `PG_OFF_RST;
            ovf_reg <= `OV_FAULT_RST;
            ovw_reg <= `OV_WARN_RST;
            uvf_reg <= `UV_FAULT_RST;
            uvw_reg <= `UV_WARN_RST;
            band_reg <= `VID_BAND_RST;
            dly_reg <= 4'h0;
            status_reg <= '0;
            vout_reg <= 16'h0000;
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 32'h0000_0000;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'b00;
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'b00;
            rdata_reg <= 32'h0000_0000;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            arready_reg <= 1'b1;
            pg_state_reg <= PG_LOW;
            ms_cnt_reg <= 17'd0;
            ms_left_reg <= 4'h0;
            ov_cnt_reg <= 8'd0;
            ov_trip_reg <= 1'b0;
            hs_latch_reg <= 1'b0;
            pg_reg <= 1'b0;
            hs_reg <= 1'b0;
            ls_reg <= 1'b0;
            alert_reg <= 1'b0;
            en_d_reg <= 1'b0;
            run_d_reg <= 1'b1;
        end else begin
            ctrl_reg <= ctrl_next;
            pg_on_reg <= pg_on_next;
            pg_off_reg <= pg_off_next;
            ovf_reg <= ovf_next;
            ovw_reg <= ovw_next;
            uvf_reg <= uvf_next;
            uvw_reg <= uvw_next;
            band_reg <= band_next;
            dly_reg <= dly_next;
            status_reg <= status_next;
            vout_reg <= vout_next;
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            arready_reg <= arready_next;
            pg_state_reg <= pg_state_next;
            ms_cnt_reg <= ms_cnt_next;
            ms_left_reg <= ms_left_next;
            ov_cnt_reg <= ov_cnt_next;
            ov_trip_reg <= ov_trip_next;
            hs_latch_reg <= hs_latch_next;
            pg_reg <= pg_next;
            hs_reg <= hs_next;
            ls_reg <= ls_next;
            alert_reg <= alert_next;
            en_d_reg <= enable_in;
            run_d_reg <= ctrl_reg[`CTRL_RUN_BIT];
        end
    end

    // outputs straight from flops
    assign s_axi_awready     = awready_reg;
    assign s_axi_wready      = wready_reg;
    assign s_axi_bvalid      = bvalid_reg;
    assign s_axi_bresp       = bresp_reg;
    assign s_axi_arready     = arready_reg;
    assign s_axi_rvalid      = rvalid_reg;
    assign s_axi_rresp       = rresp_reg;
    assign s_axi_rdata       = rdata_reg;
    assign power_good_output = pg_reg;
    assign high_side_drive   = hs_reg;
    assign low_side_drive    = ls_reg;
    assign alert_output      = alert_reg;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    ov_trip_delay_a: assert property (ov_above [*8] ##1 ov_above [*8] ##1 ov_above [*5]
        |=> ov_trip_reg) else $error("ov trip late");
    ov_trip_early_a: assert property ($rose(ov_above) |=> !ov_trip_reg [*8])
        else $error("ov trip early");
    hs_latch_off_a: assert property (ov_trip_reg && !ctrl_reg[`CTRL_OV_IGN_BIT]
        |=> !power_good_output ##1 !high_side_drive) else $error("hs not off");
    hs_stays_off_a: assert property (hs_latch_reg && !restart |=> hs_latch_reg)
        else $error("latch lost");
    ls_hold_on_a: assert property (hs_latch_reg && ov_above && !restart |=> low_side_drive)
        else $error("ls not on");
    ov_ignore_run_a: assert property (ctrl_reg[`CTRL_OV_IGN_BIT] && !hs_latch_reg
        && $stable(ctrl_reg) |=> !hs_latch_reg) else $error("ignored ov latched");
    ov_status_set_a: assert property (ov_trip_reg |=> status_reg[`ST_OV_FAULT]
        && alert_output) else $error("ov not flagged");
    uv_status_set_a: assert property (sense_code < uvf_reg |=> status_reg[`ST_UV_FAULT])
        else $error("uv not flagged");
    pg_no_delay_a: assert property (!ctrl_reg[`CTRL_VID_BIT] && pg_state_reg == PG_LOW
        && in_window && dly_reg == 4'h0 && !ov_trip_reg && !hs_latch_next
        |=> power_good_output)
        else $error("pg delayed");
    pg_restart_a: assert property (pg_state_reg == PG_WAIT && !in_window
        && !ctrl_reg[`CTRL_VID_BIT] |=> pg_state_reg == PG_LOW) else $error("no restart");
    vout_report_a: assert property (##1 1'b1 |-> vout_reg == $past(sense_code))
        else $error("vout stale");

    cov_ov_latch: cover property (ov_trip_reg ##1 hs_latch_reg);
    cov_pg_delay: cover property (pg_state_reg == PG_WAIT ##1 pg_state_reg == PG_HIGH);
    cov_vid_pg:   cover property (ctrl_reg[`CTRL_VID_BIT] && power_good_output);
endmodule

// [rtl/vout_mon_params.svh]
`ifndef VOUT_MON_PARAMS_SVH
`define VOUT_MON_PARAMS_SVH

// register byte offsets
`define OFF_CTRL        12'h000
`define OFF_PG_ON       12'h004
`define OFF_PG_OFF      12'h008
`define OFF_OV_FAULT    12'h00c
`define OFF_OV_WARN     12'h010
`define OFF_UV_FAULT    12'h014
`define OFF_UV_WARN     12'h018
`define OFF_PG_DELAY    12'h01c
`define OFF_READ_VOUT   12'h020
`define OFF_STATUS      12'h024
`define OFF_VID_BAND    12'h028
// ctrl bits
`define CTRL_RUN_BIT    0
`define CTRL_VID_BIT    1
`define CTRL_OV_IGN_BIT 2
`define CTRL_ZERO_BIT   3
// status bits (sticky, write one to clear)
`define ST_OV_FAULT     0
`define ST_OV_WARN      1
`define ST_UV_FAULT     2
`define ST_UV_WARN      3
`define ST_W            4
// tracking offsets in 1/256 V codes: 630 mV and 655 mV
`define PG_TRACK_MV     630
`define OV_TRACK_MV     655
`define PG_TRACK_CODE   16'd161
`define OV_TRACK_CODE   16'd168
// timing at 100 MHz
`define CLK_MHZ         100
`define OV_TRIP_NS      200
`define OV_TRIP_CYC     8'd20
`define MS_CYC_DEFAULT  100000
`define PG_DELAY_MAX    4'd10
// reset values
`define CTRL_RST        4'h1
`define PG_ON_RST       16'h00e6
`define PG_OFF_RST      16'h00cc
`define OV_FAULT_RST    16'h0133
`define OV_WARN_RST     16'h0120
`define UV_FAULT_RST    16'h00b3
`define UV_WARN_RST     16'h00c0
`define VID_BAND_RST    16'h000d
`define AXI_OKAY        2'b00
`define AXI_SLVERR      2'b10

`endif

// [rtl/vout_mon_pkg.sv]
package vout_mon_pkg;
    typedef logic [15:0] code_t;
    typedef enum logic [1:0] {
        PG_LOW   = 2'b00,
        PG_WAIT  = 2'b01,
        PG_HIGH  = 2'b10
    } pg_state_t;
endpackage

// [tb/sense_model.sv]
`timescale 1ns/1ps

module sense_model
    import vout_mon_pkg::*;
#(
    parameter logic [15:0] INIT = 16'h0100
) (
    // clock
    input  wire logic  sys_clk,
    // requested output level and ramp mode
    input  wire code_t level_req,
    input  wire logic  slow,
    // digitized sense sample
    output code_t      sense_code
);
    import vout_mon_pkg::*;

    initial sense_code = INIT;

    // output jumps to the request, or slews one code a cycle like a real rail
    always @(posedge sys_clk) begin
        if (!slow || sense_code == level_req) begin
            sense_code <= level_req;
        end else if (sense_code < level_req) begin
            sense_code <= sense_code + 16'h0001;
        end else begin
            sense_code <= sense_code - 16'h0001;
        end
    end
endmodule

// [tb/vout_monitor_power_good_output_ovp_bench.sv]
`timescale 1ns/1ps
`include "vout_mon_params.svh"

module vout_monitor_power_good_output_ovp_bench;
    import vout_mon_pkg::*;
    localparam int PG = 0, HS = 1, LS = 2, AL = 3;
    localparam logic [11:0] RA [9] = '{`OFF_CTRL, `OFF_PG_ON, `OFF_PG_OFF, `OFF_OV_FAULT,
        `OFF_OV_WARN, `OFF_UV_FAULT, `OFF_UV_WARN, `OFF_PG_DELAY, `OFF_VID_BAND};
    localparam logic [31:0] RV [9] = '{32'h1, 32'he6, 32'hcc, 32'h133, 32'h120, 32'hb3,
        32'hc0, 32'h0, 32'hd};
    logic        sys_clk, rst, awvalid, wvalid, bready, arvalid, rready, en, fault, slow;
    logic        awready, wready, bvalid, arready, rvalid, pg, hs, ls, alert;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    code_t       sense, target, boot, level;
    int          n_mismatch, n_compared;

    sense_model PARTNER (.sys_clk(sys_clk), .level_req(level), .slow(slow), .sense_code(sense));

    vout_monitor_power_good_output_ovp #(.MS_CYC(10)) DUT (
        .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sense_code(sense), .vout_target(target), .boot_code(boot), .enable_in(en),
        .conv_fault(fault), .power_good_output(pg), .high_side_drive(hs),
        .low_side_drive(ls), .alert_output(alert));

    // verdict and end of run
    task automatic stop_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // word and pin comparisons
    task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_b(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected pin at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic pin(input int i);
        case (i)
            PG: return pg;
            HS: return hs;
            LS: return ls;
            default: return alert;
        endcase
    endfunction

    // bounded wait for a pin level, settled values sampled on the falling edge
    task automatic wait_pin(input int i, input logic v, input int bound);
        int k;
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while (pin(i) !== v && k < bound);
        cmp_b(pin(i), v);
        if (pin(i) !== v) stop_test();
        @(posedge sys_clk);
    endtask

    task automatic hold_pin(input int i, input logic v, input int n);
        repeat (n) begin
            @(negedge sys_clk);
            cmp_b(pin(i), v);
        end
        @(posedge sys_clk);
    endtask

    // axi4-lite write: address and data offered together, held until each is taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        logic aw_t, w_t, b_t;
        logic [1:0] r;
        b_t = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 50 && !b_t; k++) begin
            @(negedge sys_clk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            r = bresp;
            @(posedge sys_clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end
        if (!b_t) begin
            n_mismatch++;
            stop_test();
        end
        cmp_w({30'h0, r}, {30'h0, er});
    endtask

    // axi4-lite read with data and response compared
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        logic a_t, r_t;
        logic [31:0] d;
        logic [1:0] r;
        r_t = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 50 && !r_t; k++) begin
            @(negedge sys_clk);
            a_t = arvalid && arready;
            r_t = rvalid;
            d = rdata;
            r = rresp;
            @(posedge sys_clk);
            if (a_t) arvalid <= 1'b0;
        end
        if (!r_t) begin
            n_mismatch++;
            stop_test();
        end
        cmp_w(d, ed);
        cmp_w({30'h0, r}, {30'h0, er});
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, fault, slow} = '0;
        {awaddr, araddr, wdata} = '0;
        {en, rst} = 2'b11;
        {level, target, boot} = {16'h0100, 16'h0100, 16'h0100};
        {n_mismatch, n_compared} = '0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        // reset values, read-only and unmapped places
        for (int i = 0; i < 9; i++) rd(RA[i], RV[i], `AXI_OKAY);
        rd(`OFF_READ_VOUT, 32'h100, `AXI_OKAY);
        rd(12'h100, 32'h0, `AXI_SLVERR);
        wr(`OFF_READ_VOUT, 32'h5, `AXI_SLVERR);
        wait_pin(PG, 1'b1, 10);
        $display("test registers done");
        // window hysteresis, undervoltage warning, assertion delay and its restart
        wr(`OFF_PG_DELAY, 32'h2, `AXI_OKAY);
        level <= 16'h00d0;
        hold_pin(PG, 1'b1, 5);
        level <= 16'h00b8;
        wait_pin(PG, 1'b0, 10);
        rd(`OFF_STATUS, 32'h8, `AXI_OKAY);
        wait_pin(AL, 1'b1, 5);
        level <= 16'h00d0;
        hold_pin(PG, 1'b0, 30);
        level <= 16'h0100;
        hold_pin(PG, 1'b0, 12);
        level <= 16'h00b8;
        repeat (2) @(posedge sys_clk);
        level <= 16'h0100;
        hold_pin(PG, 1'b0, 15);
        wait_pin(PG, 1'b1, 15);
        wr(`OFF_STATUS, 32'hf, `AXI_OKAY);
        rd(`OFF_STATUS, 32'h0, `AXI_OKAY);
        wait_pin(AL, 1'b0, 5);
        $display("test window done");
        // thresholds far below the output voltage follow it at a fixed offset
        wr(`OFF_PG_DELAY, 32'h0, `AXI_OKAY);
        level <= 16'h0040;
        wait_pin(PG, 1'b0, 10);
        wr(`OFF_PG_ON, 32'h10, `AXI_OKAY);
        wr(`OFF_PG_OFF, 32'h8, `AXI_OKAY);
        hold_pin(PG, 1'b0, 10);
        level <= 16'h0080;
        wait_pin(PG, 1'b1, 10);
        wr(`OFF_PG_ON, 32'he6, `AXI_OKAY);
        wr(`OFF_PG_OFF, 32'hcc, `AXI_OKAY);
        level <= 16'h0100;
        wr(`OFF_STATUS, 32'hf, `AXI_OKAY);
        $display("test tracking done");
        // latched overvoltage, released by enable and by the run bit
        wr(`OFF_OV_FAULT, 32'h300, `AXI_OKAY);
        level <= 16'h01b0;
        hold_pin(HS, 1'b1, 15);
        wait_pin(HS, 1'b0, 15);
        hold_pin(PG, 1'b0, 2);
        hold_pin(LS, 1'b1, 2);
        rd(`OFF_STATUS, 32'h3, `AXI_OKAY);
        level <= 16'h0100;
        wait_pin(LS, 1'b0, 5);
        hold_pin(HS, 1'b0, 10);
        en <= 1'b0;
        repeat (2) @(posedge sys_clk);
        en <= 1'b1;
        wait_pin(HS, 1'b1, 5);
        wr(`OFF_CTRL, 32'h3, `AXI_OKAY);
        level <= 16'h01b0;
        wait_pin(HS, 1'b0, 30);
        level <= 16'h0100;
        wr(`OFF_CTRL, 32'h2, `AXI_OKAY);
        wr(`OFF_CTRL, 32'h3, `AXI_OKAY);
        wait_pin(HS, 1'b1, 5);
        wr(`OFF_STATUS, 32'hf, `AXI_OKAY);
        $display("test overvoltage done");
        // ignored overvoltage, then power good in processor voltage mode
        wr(`OFF_CTRL, 32'h7, `AXI_OKAY);
        wr(`OFF_PG_ON, 32'h1f0, `AXI_OKAY);
        level <= 16'h01b0;
        hold_pin(HS, 1'b1, 30);
        rd(`OFF_STATUS, 32'h3, `AXI_OKAY);
        wait_pin(AL, 1'b1, 2);
        level <= 16'h0100;
        wait_pin(PG, 1'b1, 10);
        slow <= 1'b1;
        level <= 16'h00c0;
        hold_pin(PG, 1'b1, 70);
        fault <= 1'b1;
        wait_pin(PG, 1'b0, 5);
        fault <= 1'b0;
        slow <= 1'b0;
        level <= 16'h0100;
        wait_pin(PG, 1'b1, 10);
        wr(`OFF_CTRL, 32'hf, `AXI_OKAY);
        target <= 16'h0000;
        wait_pin(PG, 1'b0, 5);
        $display("test voltage id done");
        stop_test();
    end
endmodule
